// ==== gpmux_consts.svh ====
// Constants for the port pin function multiplexer.
// Included by the package, the top module and the checker; definitions only.
`ifndef GPMUX_CONSTS_SVH
`define GPMUX_CONSTS_SVH

// Port widths
`define GPMUX_PA_W 12
`define GPMUX_PB_W 12
`define GPMUX_PC_W 8
`define GPMUX_PD_W 6

// Bits of port B that reach a package pin
`define GPMUX_PB_BONDED 12'h0_CEF

// Peripheral enable reset values: A7 is the reset input, D0..D3 the test port
`define GPMUX_PA_PE_RST 12'h0_080
`define GPMUX_PB_PE_RST 12'h0_000
`define GPMUX_PC_PE_RST 8'h00
`define GPMUX_PD_PE_RST 6'h0F

// Three-way alternate select codes; the fourth code leaves the pin undriven
`define GPMUX_SEL_ALT0 2'h0
`define GPMUX_SEL_ALT1 2'h1
`define GPMUX_SEL_ALT2 2'h2

// Bit positions of the shared pins
`define GPMUX_BIT_A4 4
`define GPMUX_BIT_A6 6
`define GPMUX_BIT_A7 7
`define GPMUX_BIT_A8 8
`define GPMUX_BIT_B0 0
`define GPMUX_BIT_B2 2
`define GPMUX_BIT_B6 6
`define GPMUX_BIT_B7 7
`define GPMUX_BIT_C0 0
`define GPMUX_BIT_C4 4
`define GPMUX_BIT_D0 0
`define GPMUX_BIT_D1 1
`define GPMUX_BIT_D2 2
`define GPMUX_BIT_D3 3
`define GPMUX_BIT_D5 5

`endif

// ==== gpmux_pkg.sv ====
// Types for the port pin function multiplexer.
// Assumes gpmux_consts.svh is on the include path.
`include "gpmux_consts.svh"

package gpmux_pkg;

   typedef logic [`GPMUX_PA_W-1:0] gpmux_pa_t;
   typedef logic [`GPMUX_PB_W-1:0] gpmux_pb_t;
   typedef logic [`GPMUX_PC_W-1:0] gpmux_pc_t;
   typedef logic [`GPMUX_PD_W-1:0] gpmux_pd_t;
   typedef logic [1:0] gpmux_sel3_t;

endpackage : gpmux_pkg

// ==== gpmux_pin_mux.sv ====
// Pin function multiplexer for the four general-purpose ports A to D.
// Assumes pin inputs and all control inputs are synchronous to clk;
// the pad ring resolves each pin from its output and output enable.
`timescale 1ns/100ps
`include "gpmux_consts.svh"

module gpmux_pin_mux
   import gpmux_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // Package pins
   input wire gpmux_pa_t pa_pin_in,
   output gpmux_pa_t pa_pin_out,
   output gpmux_pa_t pa_pin_oe,
   input wire gpmux_pb_t pb_pin_in,
   output gpmux_pb_t pb_pin_out,
   output gpmux_pb_t pb_pin_oe,
   input wire gpmux_pc_t pc_pin_in,
   output gpmux_pc_t pc_pin_out,
   output gpmux_pc_t pc_pin_oe,
   input wire gpmux_pd_t pd_pin_in,
   output gpmux_pd_t pd_pin_out,
   output gpmux_pd_t pd_pin_oe,
   // Port logic side
   input wire gpmux_pa_t pa_gpio_out,
   input wire gpmux_pa_t pa_gpio_oe,
   input wire gpmux_pa_t pa_periph_en,
   output gpmux_pa_t pa_gpio_in,
   input wire gpmux_pb_t pb_gpio_out,
   input wire gpmux_pb_t pb_gpio_oe,
   input wire gpmux_pb_t pb_periph_en,
   output gpmux_pb_t pb_gpio_in,
   input wire gpmux_pc_t pc_gpio_out,
   input wire gpmux_pc_t pc_gpio_oe,
   input wire gpmux_pc_t pc_periph_en,
   output gpmux_pc_t pc_gpio_in,
   input wire gpmux_pd_t pd_gpio_out,
   input wire gpmux_pd_t pd_gpio_oe,
   input wire gpmux_pd_t pd_periph_en,
   output gpmux_pd_t pd_gpio_in,
   // Alternate function select fields
   input wire gpmux_sel3_t sel_a4,
   input wire logic sel_a6,
   input wire gpmux_sel3_t sel_a8,
   input wire logic sel_b0,
   input wire gpmux_sel3_t sel_b2,
   input wire gpmux_sel3_t sel_b6,
   input wire logic sel_b7,
   input wire logic sel_c0,
   input wire logic sel_c4,
   // Clock pin select field and clock generator enable
   input wire logic sel_d5,
   input wire logic pll_external_clock_input_en,
   // Peripheral outputs toward the pins
   input wire logic pwm_output_4,
   input wire logic timer_a_channel_2_out,
   input wire logic timer_a_channel_2_oe,
   input wire logic timer_a_channel_0_out,
   input wire logic timer_a_channel_0_oe,
   input wire logic spi_serial_clock_out,
   input wire logic spi_serial_clock_oe,
   input wire logic i2c_scl_out,
   input wire logic i2c_scl_oe,
   input wire logic i2c_sda_out,
   input wire logic i2c_sda_oe,
   input wire logic serial_transmit_data,
   input wire logic test_data_out,
   input wire logic test_data_out_oe,
   input wire logic crystal_oscillator_output,
   // Pin levels toward the peripherals
   output logic fault_input_0,
   output logic fault_input_1,
   output logic timer_a_channel_0_in,
   output logic timer_a_channel_2_in,
   output logic comparator_a_input_1,
   output logic spi_serial_clock_in,
   output logic spi_data_input,
   output logic pwm_source_input_0,
   output logic i2c_scl_in,
   output logic i2c_sda_in,
   output logic serial_receive_data,
   output logic external_clock_input,
   output logic converter_a_input_0,
   output logic comparator_a_input_3,
   output logic converter_b_input_0,
   output logic comparator_b_input_3,
   output logic reset_in_n,
   output logic test_data_in,
   output logic test_clock,
   output logic test_mode_select
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // One bit picked by a three-way select; the spare code yields zero
   function automatic logic sel3(input gpmux_sel3_t sel, input logic v0, input logic v1,
                                 input logic v2);
      sel3 = (sel == `GPMUX_SEL_ALT0) ? v0 :
             (sel == `GPMUX_SEL_ALT1) ? v1 :
             (sel == `GPMUX_SEL_ALT2) ? v2 : 1'b0;
   endfunction : sel3

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral enable state

   gpmux_pa_t pa_pe_ff;
   gpmux_pb_t pb_pe_ff;
   gpmux_pc_t pc_pe_ff;
   gpmux_pd_t pd_pe_ff;

   // Enables with their reset functions; software values follow a cycle later
   // reset input default
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pa_pe_ff <= `GPMUX_PA_PE_RST;
         pb_pe_ff <= `GPMUX_PB_PE_RST;
         pc_pe_ff <= `GPMUX_PC_PE_RST;
         pd_pe_ff <= `GPMUX_PD_PE_RST;
      end
      else
      begin
         pa_pe_ff <= pa_periph_en;
         pb_pe_ff <= pb_periph_en & `GPMUX_PB_BONDED;
         pc_pe_ff <= pc_periph_en;
         pd_pe_ff <= pd_periph_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alternate drive per pin

   gpmux_pa_t pa_alt_out;
   gpmux_pa_t pa_alt_oe;
   gpmux_pb_t pb_alt_out;
   gpmux_pb_t pb_alt_oe;
   gpmux_pd_t pd_alt_out;
   gpmux_pd_t pd_alt_oe;

   always_comb
   begin
      pa_alt_out = '0;
      pa_alt_oe = '0;
      pa_alt_out[`GPMUX_BIT_A4] = sel3(sel_a4, pwm_output_4, timer_a_channel_2_out, 1'b0);
      pa_alt_oe[`GPMUX_BIT_A4] = sel3(sel_a4, 1'b1, timer_a_channel_2_oe, 1'b0);
      pa_alt_out[`GPMUX_BIT_A6] = sel_a6 & timer_a_channel_0_out;
      pa_alt_oe[`GPMUX_BIT_A6] = sel_a6 & timer_a_channel_0_oe;
      pa_alt_out[`GPMUX_BIT_A8] = sel3(sel_a8, 1'b0, timer_a_channel_2_out, 1'b0);
      pa_alt_oe[`GPMUX_BIT_A8] = sel3(sel_a8, 1'b0, timer_a_channel_2_oe, 1'b0);
   end

   always_comb
   begin
      pb_alt_out = '0;
      pb_alt_oe = '0;
      pb_alt_out[`GPMUX_BIT_B0] = sel_b0 ? i2c_scl_out : spi_serial_clock_out;
      pb_alt_oe[`GPMUX_BIT_B0] = sel_b0 ? i2c_scl_oe : spi_serial_clock_oe;
      pb_alt_out[`GPMUX_BIT_B2] = sel3(sel_b2, 1'b0, timer_a_channel_2_out, 1'b0);
      pb_alt_oe[`GPMUX_BIT_B2] = sel3(sel_b2, 1'b0, timer_a_channel_2_oe, 1'b0);
      pb_alt_out[`GPMUX_BIT_B6] = sel3(sel_b6, 1'b0, i2c_sda_out, 1'b0);
      pb_alt_oe[`GPMUX_BIT_B6] = sel3(sel_b6, 1'b0, i2c_sda_oe, 1'b0);
      pb_alt_out[`GPMUX_BIT_B7] = sel_b7 ? i2c_scl_out : serial_transmit_data;
      pb_alt_oe[`GPMUX_BIT_B7] = sel_b7 ? i2c_scl_oe : 1'b1;
   end

   always_comb
   begin
      pd_alt_out = '0;
      pd_alt_oe = '0;
      pd_alt_out[`GPMUX_BIT_D1] = test_data_out;
      pd_alt_oe[`GPMUX_BIT_D1] = test_data_out_oe;
      pd_alt_out[`GPMUX_BIT_D5] = ~sel_d5 & crystal_oscillator_output;
      pd_alt_oe[`GPMUX_BIT_D5] = ~sel_d5;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive: port bit in GPIO mode, chosen alternate when enabled

   wire gpmux_pa_t nxt_pa_out = (pa_pe_ff & pa_alt_out) | (~pa_pe_ff & pa_gpio_out);
   wire gpmux_pa_t nxt_pa_oe = (pa_pe_ff & pa_alt_oe) | (~pa_pe_ff & pa_gpio_oe);
   wire gpmux_pb_t nxt_pb_out = ((pb_pe_ff & pb_alt_out) | (~pb_pe_ff & pb_gpio_out))
                                & `GPMUX_PB_BONDED;
   wire gpmux_pb_t nxt_pb_oe = ((pb_pe_ff & pb_alt_oe) | (~pb_pe_ff & pb_gpio_oe))
                               & `GPMUX_PB_BONDED;
   wire gpmux_pc_t nxt_pc_out = ~pc_pe_ff & pc_gpio_out;  // Analog alternates never drive
   wire gpmux_pc_t nxt_pc_oe = ~pc_pe_ff & pc_gpio_oe;
   wire gpmux_pd_t nxt_pd_out = (pd_pe_ff & pd_alt_out) | (~pd_pe_ff & pd_gpio_out);
   wire gpmux_pd_t nxt_pd_oe = (pd_pe_ff & pd_alt_oe) | (~pd_pe_ff & pd_gpio_oe);

   gpmux_pa_t pa_out_ff, pa_oe_ff, pa_in_ff;
   gpmux_pb_t pb_out_ff, pb_oe_ff, pb_in_ff;
   gpmux_pc_t pc_out_ff, pc_oe_ff, pc_in_ff;
   gpmux_pd_t pd_out_ff, pd_oe_ff, pd_in_ff;

   // Registered pin drive and port read-back; all pins released in reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         {pa_out_ff, pa_oe_ff, pa_in_ff} <= '0;
         {pb_out_ff, pb_oe_ff, pb_in_ff} <= '0;
         {pc_out_ff, pc_oe_ff, pc_in_ff} <= '0;
         {pd_out_ff, pd_oe_ff, pd_in_ff} <= '0;
      end
      else
      begin
         {pa_out_ff, pa_oe_ff, pa_in_ff} <= {nxt_pa_out, nxt_pa_oe, pa_pin_in};
         {pb_out_ff, pb_oe_ff} <= {nxt_pb_out, nxt_pb_oe};
         pb_in_ff <= pb_pin_in & `GPMUX_PB_BONDED;
         {pc_out_ff, pc_oe_ff, pc_in_ff} <= {nxt_pc_out, nxt_pc_oe, pc_pin_in};
         {pd_out_ff, pd_oe_ff, pd_in_ff} <= {nxt_pd_out, nxt_pd_oe, pd_pin_in};
      end
   end

   assign {pa_pin_out, pa_pin_oe, pa_gpio_in} = {pa_out_ff, pa_oe_ff, pa_in_ff};
   assign {pb_pin_out, pb_pin_oe, pb_gpio_in} = {pb_out_ff, pb_oe_ff, pb_in_ff};
   assign {pc_pin_out, pc_pin_oe, pc_gpio_in} = {pc_out_ff, pc_oe_ff, pc_in_ff};
   assign {pd_pin_out, pd_pin_oe, pd_gpio_in} = {pd_out_ff, pd_oe_ff, pd_in_ff};

   ////////////////////////////////////////////////////////////////////////////
   // Pin levels toward the peripherals

   // Pin is routed to a given alternate only when enabled and selected
   wire a4_ta2 = pa_pe_ff[`GPMUX_BIT_A4] & (sel_a4 == `GPMUX_SEL_ALT1);
   wire a4_flt = pa_pe_ff[`GPMUX_BIT_A4] & (sel_a4 == `GPMUX_SEL_ALT2);
   wire a6_flt = pa_pe_ff[`GPMUX_BIT_A6] & ~sel_a6;
   wire a6_ta0 = pa_pe_ff[`GPMUX_BIT_A6] & sel_a6;
   wire a8_flt = pa_pe_ff[`GPMUX_BIT_A8] & (sel_a8 == `GPMUX_SEL_ALT0);
   wire a8_ta2 = pa_pe_ff[`GPMUX_BIT_A8] & (sel_a8 == `GPMUX_SEL_ALT1);
   wire a8_cmp = pa_pe_ff[`GPMUX_BIT_A8] & (sel_a8 == `GPMUX_SEL_ALT2);
   wire b0_spi = pb_pe_ff[`GPMUX_BIT_B0] & ~sel_b0;
   wire b0_scl = pb_pe_ff[`GPMUX_BIT_B0] & sel_b0;
   wire b2_spi = pb_pe_ff[`GPMUX_BIT_B2] & (sel_b2 == `GPMUX_SEL_ALT0);
   wire b2_ta2 = pb_pe_ff[`GPMUX_BIT_B2] & (sel_b2 == `GPMUX_SEL_ALT1);
   wire b2_src = pb_pe_ff[`GPMUX_BIT_B2] & (sel_b2 == `GPMUX_SEL_ALT2);
   wire b6_rxd = pb_pe_ff[`GPMUX_BIT_B6] & (sel_b6 == `GPMUX_SEL_ALT0);
   wire b6_sda = pb_pe_ff[`GPMUX_BIT_B6] & (sel_b6 == `GPMUX_SEL_ALT1);
   wire b6_clk = pb_pe_ff[`GPMUX_BIT_B6] & (sel_b6 == `GPMUX_SEL_ALT2);
   wire b7_scl = pb_pe_ff[`GPMUX_BIT_B7] & sel_b7;
   wire c0_en = pc_pe_ff[`GPMUX_BIT_C0];
   wire c4_en = pc_pe_ff[`GPMUX_BIT_C4];
   wire d5_clk = pd_pe_ff[`GPMUX_BIT_D5] & sel_d5;

   // Registered peripheral inputs; idle level 0, I2C, serial and reset idle high
   // fault and timer inputs
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         {fault_input_0, fault_input_1, timer_a_channel_0_in, timer_a_channel_2_in} <= '0;
         {comparator_a_input_1, spi_serial_clock_in, spi_data_input} <= '0;
         {pwm_source_input_0, external_clock_input} <= '0;
         {i2c_scl_in, i2c_sda_in, serial_receive_data, reset_in_n} <= 4'h0_F;
         {converter_a_input_0, comparator_a_input_3} <= '0;
         {converter_b_input_0, comparator_b_input_3} <= '0;
         {test_data_in, test_clock, test_mode_select} <= '0;
      end
      else
      begin
         fault_input_0 <= a6_flt & pa_pin_in[`GPMUX_BIT_A6];
         fault_input_1 <= a4_flt ? pa_pin_in[`GPMUX_BIT_A4] : (a8_flt & pa_pin_in[`GPMUX_BIT_A8]);
         timer_a_channel_0_in <= a6_ta0 & pa_pin_in[`GPMUX_BIT_A6];
         timer_a_channel_2_in <= a4_ta2 ? pa_pin_in[`GPMUX_BIT_A4] :
                                 a8_ta2 ? pa_pin_in[`GPMUX_BIT_A8] :
                                 (b2_ta2 & pb_pin_in[`GPMUX_BIT_B2]);
         comparator_a_input_1 <= a8_cmp & pa_pin_in[`GPMUX_BIT_A8];
         spi_serial_clock_in <= b0_spi & pb_pin_in[`GPMUX_BIT_B0];
         spi_data_input <= b2_spi & pb_pin_in[`GPMUX_BIT_B2];
         pwm_source_input_0 <= b2_src & pb_pin_in[`GPMUX_BIT_B2];
         i2c_scl_in <= b0_scl ? pb_pin_in[`GPMUX_BIT_B0] :
                       b7_scl ? pb_pin_in[`GPMUX_BIT_B7] : 1'b1;
         i2c_sda_in <= b6_sda ? pb_pin_in[`GPMUX_BIT_B6] : 1'b1;
         serial_receive_data <= b6_rxd ? pb_pin_in[`GPMUX_BIT_B6] : 1'b1;
         external_clock_input <= pll_external_clock_input_en &
                                 (b6_clk ? pb_pin_in[`GPMUX_BIT_B6] :
                                  (d5_clk & pd_pin_in[`GPMUX_BIT_D5]));
         converter_a_input_0 <= c0_en & ~sel_c0 & pc_pin_in[`GPMUX_BIT_C0];
         comparator_a_input_3 <= c0_en & sel_c0 & pc_pin_in[`GPMUX_BIT_C0];
         converter_b_input_0 <= c4_en & ~sel_c4 & pc_pin_in[`GPMUX_BIT_C4];
         comparator_b_input_3 <= c4_en & sel_c4 & pc_pin_in[`GPMUX_BIT_C4];
         reset_in_n <= pa_pe_ff[`GPMUX_BIT_A7] ? pa_pin_in[`GPMUX_BIT_A7] : 1'b1;
         test_data_in <= pd_pe_ff[`GPMUX_BIT_D0] & pd_pin_in[`GPMUX_BIT_D0];
         test_clock <= pd_pe_ff[`GPMUX_BIT_D2] & pd_pin_in[`GPMUX_BIT_D2];
         test_mode_select <= pd_pe_ff[`GPMUX_BIT_D3] & pd_pin_in[`GPMUX_BIT_D3];
      end
   end

endmodule : gpmux_pin_mux

// ==== gpmux_periph_model.sv ====
// Model of the on-chip peripherals that share the package pins.
// Assumes the testbench sets one level and one enable for all of them.
`timescale 1ns/100ps

module gpmux_periph_model
(
   input wire logic drv_val,
   input wire logic drv_oe,
   output logic pwm_output_4,
   output logic timer_a_channel_2_out,
   output logic timer_a_channel_2_oe,
   output logic timer_a_channel_0_out,
   output logic timer_a_channel_0_oe,
   output logic spi_serial_clock_out,
   output logic spi_serial_clock_oe,
   output logic i2c_scl_out,
   output logic i2c_scl_oe,
   output logic i2c_sda_out,
   output logic i2c_sda_oe,
   output logic serial_transmit_data,
   output logic test_data_out,
   output logic test_data_out_oe,
   output logic crystal_oscillator_output
);
   // Every peripheral output shows the same level, so a missing route still shows up
   assign {pwm_output_4, timer_a_channel_2_out, timer_a_channel_0_out} = {3{drv_val}};
   assign {spi_serial_clock_out, i2c_scl_out, i2c_sda_out} = {3{drv_val}};
   assign {serial_transmit_data, test_data_out, crystal_oscillator_output} = {3{drv_val}};
   // Output enables of the peripherals that can also listen
   assign {timer_a_channel_2_oe, timer_a_channel_0_oe, spi_serial_clock_oe} = {3{drv_oe}};
   assign {i2c_scl_oe, i2c_sda_oe, test_data_out_oe} = {3{drv_oe}};
endmodule : gpmux_periph_model

// ==== gpmux_pin_mux_chk.sv ====
// Checker for the port pin function multiplexer.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`include "gpmux_consts.svh"

module gpmux_pin_mux_chk
   import gpmux_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire gpmux_pa_t pa_pin_in,
   input wire gpmux_pa_t pa_pin_out,
   input wire gpmux_pa_t pa_pin_oe,
   input wire gpmux_pb_t pb_pin_in,
   input wire gpmux_pb_t pb_pin_out,
   input wire gpmux_pb_t pb_pin_oe,
   input wire gpmux_pb_t pb_gpio_in,
   input wire gpmux_pd_t pd_pin_in,
   input wire gpmux_pd_t pd_pin_out,
   input wire gpmux_pd_t pd_pin_oe,
   input wire gpmux_pa_t pa_gpio_out,
   input wire gpmux_pa_t pa_gpio_oe,
   input wire gpmux_pa_t pa_periph_en,
   input wire gpmux_pb_t pb_periph_en,
   input wire gpmux_pd_t pd_periph_en,
   input wire gpmux_sel3_t sel_a4,
   input wire gpmux_sel3_t sel_b6,
   input wire logic sel_b7,
   input wire logic sel_d5,
   input wire logic pll_external_clock_input_en,
   input wire logic pwm_output_4,
   input wire logic serial_transmit_data,
   input wire logic crystal_oscillator_output,
   input wire logic serial_receive_data,
   input wire logic external_clock_input,
   input wire logic reset_in_n,
   input wire logic test_clock
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drive and input paths; enables reach the pins and peripheral inputs two edges after they change
   a_unbonded_quiet: assert property ((pb_pin_oe & ~`GPMUX_PB_BONDED) == 12'h000)
      else $error("unbonded port B pin driven");
   a_unbonded_read: assert property ((pb_gpio_in & ~`GPMUX_PB_BONDED) == 12'h000)
      else $error("unbonded port B pin reads nonzero");
   a_gpio_drive: assert property (!pa_periph_en[4] ##1 1 |=>
      pa_pin_oe[4] == $past(pa_gpio_oe[4]) && (!pa_pin_oe[4] || pa_pin_out[4] == $past(pa_gpio_out[4])))
      else $error("general I/O does not own pin A4");
   a_pwm_drive: assert property (pa_periph_en[4] ##1 (pa_periph_en[4] && sel_a4 == 2'h0) |=>
      pa_pin_oe[4] && pa_pin_out[4] == $past(pwm_output_4))
      else $error("PWM output 4 not on pin A4");
   a_sel_none: assert property (pa_periph_en[4] ##1 (pa_periph_en[4] && sel_a4 == 2'h3) |=>
      !pa_pin_oe[4])
      else $error("pin A4 driven with no alternate chosen");
   a_tx_drive: assert property (pb_periph_en[7] ##1 (pb_periph_en[7] && !sel_b7) |=>
      pb_pin_oe[7] && pb_pin_out[7] == $past(serial_transmit_data))
      else $error("serial transmit not on pin B7");
   a_crystal_drive: assert property (pd_periph_en[5] ##1 (pd_periph_en[5] && !sel_d5) |=>
      pd_pin_oe[5] && pd_pin_out[5] == $past(crystal_oscillator_output))
      else $error("oscillator output not on pin D5");
   a_external_clock_input_gate: assert property (!pll_external_clock_input_en |=> !external_clock_input)
      else $error("external clock passes without clock generator enable");
   a_reset_pin: assert property (pa_periph_en[7] ##1 pa_periph_en[7] |=>
      reset_in_n == $past(pa_pin_in[7]))
      else $error("reset input does not follow pin A7");
   a_rx_route: assert property (pb_periph_en[6] ##1 (pb_periph_en[6] && sel_b6 == 2'h0) |=>
      serial_receive_data == $past(pb_pin_in[6]))
      else $error("serial receive does not follow pin B6");
   a_test_clock: assert property (pd_periph_en[2] ##1 pd_periph_en[2] |=>
      test_clock == $past(pd_pin_in[2]))
      else $error("test clock does not follow pin D2");

   // Main scenarios reached
   c_external_clock_input: cover property ($rose(external_clock_input));
   c_reset_pin: cover property ($fell(reset_in_n));
   c_pwm: cover property (pa_periph_en[4] && pa_pin_oe[4]);
endmodule : gpmux_pin_mux_chk

// ==== tb_gpio_port_pin_function_mux.sv ====
// Self-checking testbench for the port pin function multiplexer.
// Assumes the package, the header and the peripheral model are compiled first.
`timescale 1ns/100ps

module tb_gpio_port_pin_function_mux
   import gpmux_pkg::*;
;
   logic clk, rst, drv_val, drv_oe;
   gpmux_pa_t pa_pin_in, pa_pin_out, pa_pin_oe, pa_gpio_out, pa_gpio_oe, pa_periph_en, pa_gpio_in;
   gpmux_pb_t pb_pin_in, pb_pin_out, pb_pin_oe, pb_gpio_out, pb_gpio_oe, pb_periph_en, pb_gpio_in;
   gpmux_pc_t pc_pin_in, pc_pin_out, pc_pin_oe, pc_gpio_out, pc_gpio_oe, pc_periph_en, pc_gpio_in;
   gpmux_pd_t pd_pin_in, pd_pin_out, pd_pin_oe, pd_gpio_out, pd_gpio_oe, pd_periph_en, pd_gpio_in;
   gpmux_sel3_t sel_a4, sel_a8, sel_b2, sel_b6;
   logic sel_a6, sel_b0, sel_b7, sel_c0, sel_c4, sel_d5, pll_external_clock_input_en;
   logic pwm_output_4, timer_a_channel_2_out, timer_a_channel_2_oe, timer_a_channel_0_out;
   logic timer_a_channel_0_oe, spi_serial_clock_out, spi_serial_clock_oe, i2c_scl_out, i2c_scl_oe;
   logic i2c_sda_out, i2c_sda_oe, serial_transmit_data, test_data_out, test_data_out_oe;
   logic crystal_oscillator_output, fault_input_0, fault_input_1, timer_a_channel_0_in;
   logic timer_a_channel_2_in, comparator_a_input_1, spi_serial_clock_in, spi_data_input;
   logic pwm_source_input_0, i2c_scl_in, i2c_sda_in, serial_receive_data, external_clock_input;
   logic converter_a_input_0, comparator_a_input_3, converter_b_input_0, comparator_b_input_3;
   logic reset_in_n, test_data_in, test_clock, test_mode_select;
   logic [19:0] per_vec;
   int failures = 0;
   int compares = 0;
   // Rows: port, enable mask, packed selects, pin level, expected peripheral inputs
   logic [50:0] rows [26] = '{
      {2'h0, 12'h000, 16'h0000, 1'h1, 20'h0_0E08}, {2'h0, 12'h040, 16'h0000, 1'h1, 20'h8_0E08},
      {2'h0, 12'h040, 16'h2000, 1'h1, 20'h2_0E08}, {2'h0, 12'h010, 16'h4000, 1'h1, 20'h1_0E08},
      {2'h0, 12'h010, 16'h8000, 1'h1, 20'h4_0E08}, {2'h0, 12'h010, 16'hC000, 1'h1, 20'h0_0E08},
      {2'h0, 12'h100, 16'h0000, 1'h1, 20'h4_0E08}, {2'h0, 12'h100, 16'h0800, 1'h1, 20'h1_0E08},
      {2'h0, 12'h100, 16'h1000, 1'h1, 20'h0_8E08}, {2'h0, 12'h080, 16'h0000, 1'h0, 20'h0_0E00},
      {2'h1, 12'h001, 16'h0000, 1'h1, 20'h0_4E08}, {2'h1, 12'h001, 16'h0400, 1'h0, 20'h0_0608},
      {2'h1, 12'h004, 16'h0000, 1'h1, 20'h0_2E08}, {2'h1, 12'h004, 16'h0100, 1'h1, 20'h1_0E08},
      {2'h1, 12'h004, 16'h0200, 1'h1, 20'h0_1E08}, {2'h1, 12'h040, 16'h0000, 1'h0, 20'h0_0C08},
      {2'h1, 12'h040, 16'h0040, 1'h0, 20'h0_0A08}, {2'h1, 12'h040, 16'h0080, 1'h1, 20'h0_0E08},
      {2'h1, 12'h040, 16'h0082, 1'h1, 20'h0_0F08}, {2'h1, 12'h080, 16'h0020, 1'h0, 20'h0_0608},
      {2'h2, 12'h001, 16'h0000, 1'h1, 20'h0_0E88}, {2'h2, 12'h001, 16'h0010, 1'h1, 20'h0_0E48},
      {2'h2, 12'h010, 16'h0000, 1'h1, 20'h0_0E28}, {2'h2, 12'h010, 16'h0008, 1'h1, 20'h0_0E18},
      {2'h3, 12'h020, 16'h0006, 1'h1, 20'h0_0F08}, {2'h3, 12'h00F, 16'h0000, 1'h1, 20'h0_0E0F}};

   // Peripheral-facing inputs gathered for one compare
   assign per_vec = {fault_input_0, fault_input_1, timer_a_channel_0_in, timer_a_channel_2_in,
      comparator_a_input_1, spi_serial_clock_in, spi_data_input, pwm_source_input_0, i2c_scl_in,
      i2c_sda_in, serial_receive_data, external_clock_input, converter_a_input_0,
      comparator_a_input_3, converter_b_input_0, comparator_b_input_3, reset_in_n, test_data_in,
      test_clock, test_mode_select};

   gpmux_pin_mux gpmux_pin_mux_i (.*);
   gpmux_periph_model gpmux_periph_model_i (.*);

   ////////////////////////////////////////////////////////////////////////////////
   // Compare, count and report
   task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
      compares++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop

   // Enable one port's mask, load selects, set every pin to one level
   task automatic apply_row(input logic [50:0] r);
      pa_periph_en = r[48:37] & {12{r[50:49] == 2'h0}};
      pb_periph_en = r[48:37] & {12{r[50:49] == 2'h1}};
      pc_periph_en = r[44:37] & {8{r[50:49] == 2'h2}};
      pd_periph_en = r[42:37] & {6{r[50:49] == 2'h3}};
      {sel_a4, sel_a6, sel_a8, sel_b0, sel_b2, sel_b6, sel_b7, sel_c0, sel_c4, sel_d5,
         pll_external_clock_input_en} = r[36:22];
      {pa_pin_in, pb_pin_in, pc_pin_in, pd_pin_in} = {38{r[20]}};
   endtask : apply_row

   // Enable register plus output register: three edges always suffice
   task automatic settle;
      repeat (3) @(posedge clk);
      #2;
   endtask : settle

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial
   begin
      repeat (2000) @(posedge clk);
      failures++;
      report_and_stop;
   end

   // Main sequence
   initial
   begin
      {pa_pin_in, pb_pin_in, pc_pin_in, pd_pin_in, pa_gpio_out, pb_gpio_out, pc_gpio_out} = '0;
      {pd_gpio_out, pa_gpio_oe, pb_gpio_oe, pc_gpio_oe, pd_gpio_oe, drv_val, drv_oe} = '0;
      {pa_periph_en, pb_periph_en, pc_periph_en, pd_periph_en} = '0;
      {sel_a4, sel_a6, sel_a8, sel_b0, sel_b2, sel_b6, sel_b7, sel_c0, sel_c4, sel_d5} = '0;
      pll_external_clock_input_en = 1'b0;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      #2;
      chk("reset_idle", 20'h0_0E08, per_vec);
      rst = 1'b0;
      for (int i = 0; i < 26; i++)
      begin
         apply_row(rows[i]);
         settle;
         chk("periph_in", rows[i][19:0], per_vec);
      end
      apply_row({2'h0, 12'h010, 16'h0000, 1'h0, 20'h0_0000});
      pb_periph_en = 12'h080;
      pd_periph_en = 6'h22;
      {drv_val, drv_oe} = 2'h3;
      settle;
      chk("a4_drive", 20'h3, {pa_pin_oe[4], pa_pin_out[4]});
      chk("b7_drive", 20'h3, {pb_pin_oe[7], pb_pin_out[7]});
      chk("d5_drive", 20'h3, {pd_pin_oe[5], pd_pin_out[5]});
      chk("d1_drive", 20'h3, {pd_pin_oe[1], pd_pin_out[1]});
      drv_val = 1'b0;
      @(posedge clk);
      #2;
      chk("a4_follow", 20'h2, {pa_pin_oe[4], pa_pin_out[4]});
      sel_a4 = 2'h3;
      settle;
      chk("a4_none", 20'h0, pa_pin_oe[4]);
      apply_row({2'h0, 12'h000, 16'h0000, 1'h1, 20'h0_0000});
      {pa_gpio_out, pa_gpio_oe, pb_gpio_out, pb_gpio_oe} = {12'hA5A, 12'hFFF, 12'hFFF, 12'hFFF};
      settle;
      chk("pa_out", 20'h0_0A5A, pa_pin_out);
      chk("pa_oe", 20'h0_0FFF, pa_pin_oe);
      chk("pb_oe", 20'h0_0CEF, pb_pin_oe);
      chk("pb_in", 20'h0_0CEF, pb_gpio_in);
      chk("pd_in", 20'h0_003F, pd_gpio_in);
      // Analog alternates on port C never drive their pins
      pc_periph_en = 8'hFF;
      {pc_gpio_out, pc_gpio_oe} = 16'hFFFF;
      settle;
      chk("pc_oe", 20'h0, pc_pin_oe);
      chk("pa_in", 20'h0_0FFF, pa_gpio_in);
      chk("pc_in", 20'h0_00FF, pc_gpio_in);
      // Mid-run reset held across one edge, then reset functions at first edge
      rst = 1'b1;
      #2;
      chk("rst_oe", 20'h0, pa_pin_oe);
      @(posedge clk);
      #2;
      rst = 1'b0;
      @(posedge clk);
      #2;
      chk("rst_func", 20'h0_0E0F, per_vec);
      settle;
      chk("pa_oe_back", 20'h0_0FFF, pa_pin_oe);
      report_and_stop;
   end
endmodule : tb_gpio_port_pin_function_mux

bind gpmux_pin_mux gpmux_pin_mux_chk gpmux_pin_mux_chk_i (.*);
